// >>> hdl/pcslst_params.svh
// Register offsets, field positions and fixed values of the PCS lane status block
//
// Summary of operation
// (RQ1) Presence field reads binary 10
// (RQ2) Transmit fault latches high until cleared
// (RQ3) Receive fault latches high until cleared
// (RQ4) Fixed PCS type capability bits reported
// (RQ5) Two read-only package identifier words
// (RQ6) Low-power capability bits all read zero
// (RQ7) Alignment bit mirrors all-lanes-aligned state
// (RQ8) Pattern and loopback ability bits read one
// (RQ9) One sync bit per lane zero..three
// (RQ10) Enable bit selects test pattern, resets zero
// (RQ11) Select field decodes high, low, mixed, reserved
// (RQ12) This register beats alternate jitter enable
// (RQ13) Fault bits clear on read unless present
// (RQ14) Reserved bits read zero, writes ignored
`ifndef PCSLST_PARAMS_SVH
`define PCSLST_PARAMS_SVH

// =============================================================
// Register indices (byte address is four times the index)
`define PCSLST_IDX_STATUS2 14'h1008
`define PCSLST_IDX_PKGID1 14'h100e
`define PCSLST_IDX_PKGID2 14'h100f
`define PCSLST_IDX_LPCAP 14'h1014
`define PCSLST_IDX_LANE 14'h1018
`define PCSLST_IDX_TEST 14'h1019
`define PCSLST_IDX_IRQ_STAT 14'h1020
`define PCSLST_IDX_IRQ_MASK 14'h1021

// =============================================================
// Field positions
`define PCSLST_ST2_TXF 11
`define PCSLST_ST2_RXF 10
`define PCSLST_LANE_ALIGN 12
`define PCSLST_TEST_EN 2
`define PCSLST_IRQ_W 4

// =============================================================
// Fixed field values
`define PCSLST_PRESENT 2'h2
`define PCSLST_CAP_100G 1'h0
`define PCSLST_CAP_40G 1'h1
`define PCSLST_CAP_10GT 1'h0
`define PCSLST_CAP_10GX 1'h1
`define PCSLST_CAP_10GR 1'h1
`define PCSLST_LP_CAP 3'h0
`define PCSLST_PAT_ABLE 1'h1
`define PCSLST_LOOP_ABLE 1'h1
`define PCSLST_TEST_RST 3'h0

// =============================================================
// Bus answers
`define PCSLST_RESP_OKAY 2'h0
`define PCSLST_RESP_SLVERR 2'h2

`endif

// >>> hdl/pcslst_pkg.sv
// Types shared by the PCS lane status register block
`default_nettype none
package pcslst_pkg;

	// Transmit pattern the datapath is told to send
	typedef enum logic [2:0] {
		PCSLST_PAT_NORMAL,
		PCSLST_PAT_HIGH,
		PCSLST_PAT_LOW,
		PCSLST_PAT_MIXED,
		PCSLST_PAT_JITTER
	} pcslst_pat_t;

	// Live status from the PCS datapath
	typedef struct packed {
		logic tx_fault;
		logic rx_fault;
		logic lanes_aligned;
		logic [3:0] lane_sync;
	} pcslst_status_t;

	// Alternate jitter pattern request from elsewhere
	typedef struct packed {
		logic enable;
		logic [2:0] select;
	} pcslst_jitter_t;

endpackage : pcslst_pkg
`default_nettype wire

// >>> hdl/pcslst_regs.sv
// AXI4-Lite register slice for PCS status, identifiers, lane status and test pattern control
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "pcslst_params.svh"

module pcslst_regs #(
	parameter logic [15:0] ORG_ID_HI = 16'h1234, // Arbitrary identifier value
	parameter logic [5:0] ORG_ID_LO = 6'h15, // Arbitrary identifier value
	parameter logic [5:0] MODEL_NUM = 6'h2a, // Arbitrary model value
	parameter logic [3:0] REV_NUM = 4'h1, // Arbitrary revision value
	parameter int LANES = 4
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write address channel
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// Write data channel
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// Write response channel
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// Read address channel
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// Read data channel
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Datapath status and pattern control
	input wire pcslst_pkg::pcslst_status_t pcs_status,
	input wire pcslst_pkg::pcslst_jitter_t jitter_req,
	output pcslst_pkg::pcslst_pat_t pattern_mode,
	// Interrupt
	output logic irq
);
	import pcslst_pkg::*;

	if (LANES != 4) begin : g_lanes_check
		$error("pcslst_regs serves exactly four lanes");
	end

	// =============================================================
	// Write channel
	// Address and data taken in either order; response once both are held
	logic aw_have_q, w_have_q, bvalid_q;
	logic [13:0] aw_idx_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q;
	logic wr_fire;
	logic wr_mapped;

	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

	always_comb begin
		unique case (aw_idx_q)
			`PCSLST_IDX_STATUS2, `PCSLST_IDX_PKGID1, `PCSLST_IDX_PKGID2, `PCSLST_IDX_LPCAP,
			`PCSLST_IDX_LANE, `PCSLST_IDX_TEST, `PCSLST_IDX_IRQ_STAT, `PCSLST_IDX_IRQ_MASK: wr_mapped = 1'b1;
			default: wr_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			aw_idx_q <= 14'h0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			aw_idx_q <= s_axi_awaddr[15:2];
		end else if (wr_fire) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q <= 1'b0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= `PCSLST_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_mapped ? `PCSLST_RESP_OKAY : `PCSLST_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	logic wr_lane0;
	assign wr_lane0 = wr_fire && wstrb_q[0];

	// =============================================================
	// Test pattern control
	logic [2:0] test_q;
	pcslst_pat_t pattern_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			test_q <= `PCSLST_TEST_RST; // [RQ10]
		end else if (wr_lane0 && aw_idx_q == `PCSLST_IDX_TEST) begin
			test_q <= wdata_q[2:0]; // [RQ14]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pattern_q <= PCSLST_PAT_NORMAL;
		end else if (test_q[`PCSLST_TEST_EN]) begin // [RQ12]
			unique case (test_q[1:0]) // [RQ11]
				2'h0: pattern_q <= PCSLST_PAT_HIGH;
				2'h1: pattern_q <= PCSLST_PAT_LOW;
				2'h2: pattern_q <= PCSLST_PAT_MIXED;
				2'h3: pattern_q <= PCSLST_PAT_NORMAL;
			endcase
		end else if (jitter_req.enable) begin
			pattern_q <= PCSLST_PAT_JITTER;
		end else begin
			pattern_q <= PCSLST_PAT_NORMAL; // [RQ10]
		end
	end

	assign pattern_mode = pattern_q;

	// =============================================================
	// Read channel
	// Read data registered at the address edge; live status sampled there
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [13:0] ar_idx;
	logic rd_take;
	logic [15:0] rd_word;
	logic rd_mapped;
	logic txf_q, rxf_q;
	logic [`PCSLST_IRQ_W-1:0] irq_stat_q, irq_mask_q;

	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign ar_idx = s_axi_araddr[15:2];
	assign rd_take = s_axi_arvalid && s_axi_arready;

	always_comb begin
		rd_mapped = 1'b1;
		rd_word = 16'h0; // [RQ14]
		unique case (ar_idx)
			`PCSLST_IDX_STATUS2: rd_word = {`PCSLST_PRESENT, 2'h0, txf_q, rxf_q, 4'h0, // [RQ1]
				`PCSLST_CAP_100G, `PCSLST_CAP_40G, `PCSLST_CAP_10GT, 1'b0, // [RQ4]
				`PCSLST_CAP_10GX, `PCSLST_CAP_10GR};
			`PCSLST_IDX_PKGID1: rd_word = ORG_ID_HI; // [RQ5]
			`PCSLST_IDX_PKGID2: rd_word = {ORG_ID_LO, MODEL_NUM, REV_NUM}; // [RQ5]
			`PCSLST_IDX_LPCAP: rd_word = {9'h0, `PCSLST_LP_CAP, 4'h0}; // [RQ6]
			`PCSLST_IDX_LANE: rd_word = {3'h0, pcs_status.lanes_aligned, // [RQ7]
				`PCSLST_PAT_ABLE, `PCSLST_LOOP_ABLE, 6'h0, pcs_status.lane_sync}; // [RQ8] [RQ9]
			`PCSLST_IDX_TEST: rd_word = {13'h0, test_q};
			`PCSLST_IDX_IRQ_STAT: rd_word = {12'h0, irq_stat_q};
			`PCSLST_IDX_IRQ_MASK: rd_word = {12'h0, irq_mask_q};
			default: rd_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= `PCSLST_RESP_OKAY;
		end else if (rd_take) begin
			rvalid_q <= 1'b1;
			rdata_q <= {16'h0, rd_word};
			rresp_q <= rd_mapped ? `PCSLST_RESP_OKAY : `PCSLST_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// =============================================================
	// Latched faults
	// A fault present during the status read wins over the read's clear
	logic st2_read;
	assign st2_read = rd_take && ar_idx == `PCSLST_IDX_STATUS2;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txf_q <= 1'b0;
			rxf_q <= 1'b0;
		end else begin
			txf_q <= pcs_status.tx_fault || (txf_q && !st2_read); // [RQ2] [RQ13]
			rxf_q <= pcs_status.rx_fault || (rxf_q && !st2_read); // [RQ3] [RQ13]
		end
	end

	// =============================================================
	// Interrupts
	// Events: tx and rx fault rising, alignment lost, any lane sync lost
	// A clear write loses to an event in the same cycle
	logic align_prev_q;
	logic [3:0] sync_prev_q;
	logic [`PCSLST_IRQ_W-1:0] irq_event;

	assign irq_event = {|(sync_prev_q & ~pcs_status.lane_sync), align_prev_q && !pcs_status.lanes_aligned,
		pcs_status.rx_fault && !rxf_q, pcs_status.tx_fault && !txf_q};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			align_prev_q <= 1'b0;
			sync_prev_q <= 4'h0;
		end else begin
			align_prev_q <= pcs_status.lanes_aligned;
			sync_prev_q <= pcs_status.lane_sync;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= 4'h0;
		end else if (wr_lane0 && aw_idx_q == `PCSLST_IDX_IRQ_STAT) begin
			irq_stat_q <= (irq_stat_q & ~wdata_q[3:0]) | irq_event;
		end else begin
			irq_stat_q <= irq_stat_q | irq_event;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_q <= 4'h0;
		end else if (wr_lane0 && aw_idx_q == `PCSLST_IDX_IRQ_MASK) begin
			irq_mask_q <= wdata_q[3:0];
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	// =============================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_status_read;
		rd_take && ar_idx == `PCSLST_IDX_STATUS2;
	endsequence

	sequence s_lane_read;
		rd_take && ar_idx == `PCSLST_IDX_LANE;
	endsequence

	property p_presence;
		s_status_read |=> s_axi_rvalid && s_axi_rdata[15:12] == 4'h8;
	endproperty
	a_presence: assert property (p_presence) else $error("presence field wrong"); // [RQ1]

	property p_txf_latch;
		pcs_status.tx_fault |=> txf_q;
	endproperty
	a_txf_latch: assert property (p_txf_latch) else $error("tx fault not latched"); // [RQ2]

	property p_rxf_hold;
		rxf_q && !st2_read |=> rxf_q;
	endproperty
	a_rxf_hold: assert property (p_rxf_hold) else $error("rx fault dropped unread"); // [RQ3]

	property p_caps;
		s_status_read |=> s_axi_rdata[5:0] == 6'h13 && s_axi_rdata[31:16] == 16'h0;
	endproperty
	a_caps: assert property (p_caps) else $error("capability bits wrong"); // [RQ4]

	property p_lane;
		s_lane_read |=> s_axi_rdata[15:0] == {3'h0, $past(pcs_status.lanes_aligned), 2'h3, 6'h0,
			$past(pcs_status.lane_sync)};
	endproperty
	a_lane: assert property (p_lane) else $error("lane status wrong"); // [RQ7]

	property p_fault_clear;
		s_status_read ##0 !pcs_status.tx_fault ##1 !pcs_status.tx_fault |=> !txf_q;
	endproperty
	a_fault_clear: assert property (p_fault_clear) else $error("tx fault not cleared by read"); // [RQ13]

	property p_priority;
		test_q == 3'h4 && jitter_req.enable |=> pattern_mode == PCSLST_PAT_HIGH;
	endproperty
	a_priority: assert property (p_priority) else $error("pattern priority wrong"); // [RQ12]

	property p_decode;
		test_q == 3'h6 ##1 test_q == 3'h6 |-> pattern_mode == PCSLST_PAT_MIXED;
	endproperty
	a_decode: assert property (p_decode) else $error("pattern select decode wrong"); // [RQ11]

	property p_disabled;
		!test_q[2] && !jitter_req.enable |=> pattern_mode == PCSLST_PAT_NORMAL;
	endproperty
	a_disabled: assert property (p_disabled) else $error("pattern sent while disabled"); // [RQ10]

	property p_lp_zero;
		rd_take && ar_idx == `PCSLST_IDX_LPCAP |=> s_axi_rdata == 32'h0;
	endproperty
	a_lp_zero: assert property (p_lp_zero) else $error("low power bits not zero"); // [RQ6]

	property p_txf_hold;
		txf_q && !st2_read |=> txf_q;
	endproperty
	a_txf_hold: assert property (p_txf_hold) else $error("tx fault dropped unread"); // [RQ2]

	property p_rxf_latch;
		pcs_status.rx_fault |=> rxf_q;
	endproperty
	a_rxf_latch: assert property (p_rxf_latch) else $error("rx fault not latched"); // [RQ3]

	property p_pkgid;
		rd_take && ar_idx == `PCSLST_IDX_PKGID2 |=> s_axi_rdata == {16'h0, ORG_ID_LO, MODEL_NUM, REV_NUM};
	endproperty
	a_pkgid: assert property (p_pkgid) else $error("package identifier word wrong"); // [RQ5]

	property p_test_write;
		wr_lane0 && aw_idx_q == `PCSLST_IDX_TEST |=> test_q[`PCSLST_TEST_EN] == $past(wdata_q[`PCSLST_TEST_EN]);
	endproperty
	a_test_write: assert property (p_test_write) else $error("test enable not written"); // [RQ10]

	property p_strobe_off;
		wr_fire && !wstrb_q[0] |=> $stable(test_q) && $stable(irq_mask_q);
	endproperty
	a_strobe_off: assert property (p_strobe_off) else $error("write without strobe took effect"); // [RQ14]

	property p_unmapped_read;
		rd_take && !rd_mapped |=> s_axi_rresp == `PCSLST_RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read answer wrong"); // [RQ14]

	property p_tx_event;
		pcs_status.tx_fault && !txf_q |=> irq_stat_q[0];
	endproperty
	a_tx_event: assert property (p_tx_event) else $error("tx fault event not recorded"); // [RQ2]

	property p_align_event;
		$past(aresetn) && $fell(pcs_status.lanes_aligned) |=> irq_stat_q[2];
	endproperty
	a_align_event: assert property (p_align_event) else $error("alignment loss not recorded"); // [RQ7]

	property p_sync_event;
		$past(aresetn) && |($past(pcs_status.lane_sync) & ~pcs_status.lane_sync) |=> irq_stat_q[3];
	endproperty
	a_sync_event: assert property (p_sync_event) else $error("lane sync loss not recorded"); // [RQ9]

	property p_irq_masked;
		irq_mask_q == 4'h0 |-> !irq;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("interrupt raised while masked"); // [RQ2]

endmodule : pcslst_regs

`default_nettype wire

// >>> hdl/pcslst_fix_note_unused.sv
// Holds no logic; the register slice lives in pcslst_regs.sv

// >>> bench/pcs_lane_status_test_regs_bench.sv
// Self-checking bench for the PCS lane status register slice
`timescale 1ns/10ps
`default_nettype none
`include "pcslst_params.svh"

module pcs_lane_status_test_regs_bench;
	import pcslst_pkg::*;

	// ============================================================
	// Signals and design under test
	localparam logic [15:0] ID_HI = 16'h5a3c; // Arbitrary identifier value
	localparam logic [5:0] ID_LO = 6'h2d; // Arbitrary identifier value
	localparam logic [5:0] MODEL = 6'h17; // Arbitrary model value
	localparam logic [3:0] REV = 4'h9; // Arbitrary revision value
	localparam logic [15:0] A_ST2 = {`PCSLST_IDX_STATUS2, 2'h0};
	localparam logic [15:0] A_LANE = {`PCSLST_IDX_LANE, 2'h0};
	localparam logic [15:0] A_TEST = {`PCSLST_IDX_TEST, 2'h0};
	localparam logic [15:0] A_IST = {`PCSLST_IDX_IRQ_STAT, 2'h0};
	localparam logic [15:0] A_IMSK = {`PCSLST_IDX_IRQ_MASK, 2'h0};
	localparam logic [1:0] OK = `PCSLST_RESP_OKAY;
	localparam logic [1:0] SLV = `PCSLST_RESP_SLVERR;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [15:0] awaddr = 16'h0, araddr = 16'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	pcslst_status_t pcs_status = '0;
	pcslst_jitter_t jitter_req = '0;
	pcslst_pat_t pattern_mode;
	int miscompares = 0, n_tests = 0;

	pcslst_regs #(.ORG_ID_HI(ID_HI), .ORG_ID_LO(ID_LO), .MODEL_NUM(MODEL), .REV_NUM(REV), .LANES(4)) u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.pcs_status(pcs_status), .jitter_req(jitter_req), .pattern_mode(pattern_mode), .irq(irq));

	initial begin
		forever #25 aclk = ~aclk;
	end

	// ============================================================
	// Compare, bus and closing tasks
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_pat(input pcslst_pat_t got, input pcslst_pat_t exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_pat

	task automatic stop_test;
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	// Entered and left just after a rising edge; answers taken at the rising edge
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
		int t;
		logic ap, wp, bv;
		logic [1:0] r;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ap = 1'b1;
		wp = 1'b1;
		bv = 1'b0;
		t = 0;
		while ((ap || wp) && t < 50) begin
			@(posedge aclk);
			if (ap && awready) begin
				awvalid <= 1'b0;
				ap = 1'b0;
			end
			if (wp && wready) begin
				wvalid <= 1'b0;
				wp = 1'b0;
			end
			t++;
		end
		while (!bv && t < 100) begin
			@(posedge aclk);
			bv = bvalid;
			r = bresp;
			t++;
		end
		chk_word({31'h0, bv}, 32'h1);
		chk_word({30'h0, r}, {30'h0, er});
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
		int t;
		logic s;
		logic [31:0] d;
		logic [1:0] r;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		s = 1'b0;
		t = 0;
		while (!s && t < 50) begin
			@(posedge aclk);
			s = arready;
			t++;
		end
		arvalid <= 1'b0;
		s = 1'b0;
		while (!s && t < 100) begin
			@(posedge aclk);
			s = rvalid;
			d = rdata;
			r = rresp;
			t++;
		end
		chk_word(d, e);
		chk_word({30'h0, r}, {30'h0, er});
	endtask : rd

	task automatic settle;
		@(posedge aclk);
		@(negedge aclk);
	endtask : settle

	// ============================================================
	// Scenarios
	task automatic test_fixed_words;
		rd(A_ST2, 32'h8013, OK);
		rd({`PCSLST_IDX_PKGID1, 2'h0}, {16'h0, ID_HI}, OK);
		rd({`PCSLST_IDX_PKGID2, 2'h0}, {16'h0, ID_LO, MODEL, REV}, OK);
		rd({`PCSLST_IDX_LPCAP, 2'h0}, 32'h0, OK);
		rd(A_TEST, 32'h0, OK);
		wstrb <= 4'he;
		wr(A_TEST, 32'h4, OK);
		wstrb <= 4'hf;
		rd(A_TEST, 32'h0, OK);
		wr(A_ST2, 32'hffff_ffff, OK);
		rd(A_ST2, 32'h8013, OK);
		wr(16'h4100, 32'h1, SLV);
		rd(16'h4100, 32'h0, SLV);
	endtask : test_fixed_words

	task automatic test_faults;
		pcs_status.tx_fault <= 1'b1;
		@(posedge aclk);
		pcs_status.tx_fault <= 1'b0;
		rd(A_ST2, 32'h8813, OK);
		rd(A_ST2, 32'h8013, OK);
		pcs_status.rx_fault <= 1'b1;
		@(posedge aclk);
		rd(A_ST2, 32'h8413, OK);
		pcs_status.rx_fault <= 1'b0;
		rd(A_ST2, 32'h8413, OK);
		rd(A_ST2, 32'h8013, OK);
	endtask : test_faults

	task automatic test_irq;
		wr(A_IST, 32'hf, OK);
		rd(A_IST, 32'h0, OK);
		pcs_status.tx_fault <= 1'b1;
		@(posedge aclk);
		pcs_status.tx_fault <= 1'b0;
		settle();
		chk_word({31'h0, irq}, 32'h0);
		@(posedge aclk);
		rd(A_IST, 32'h1, OK);
		wr(A_IMSK, 32'h1, OK);
		settle();
		chk_word({31'h0, irq}, 32'h1);
		@(posedge aclk);
		wr(A_IST, 32'h1, OK);
		settle();
		chk_word({31'h0, irq}, 32'h0);
		@(posedge aclk);
		rd(A_ST2, 32'h8813, OK);
	endtask : test_irq

	task automatic test_lanes;
		pcs_status.lanes_aligned <= 1'b1;
		pcs_status.lane_sync <= 4'ha;
		@(posedge aclk);
		wr(A_IST, 32'hf, OK);
		rd(A_LANE, 32'h1c0a, OK);
		pcs_status.lanes_aligned <= 1'b0;
		pcs_status.lane_sync <= 4'h5;
		@(posedge aclk);
		rd(A_LANE, 32'h0c05, OK);
		rd(A_IST, 32'hc, OK);
		wr(A_IMSK, 32'hc, OK);
		settle();
		chk_word({31'h0, irq}, 32'h1);
		@(posedge aclk);
	endtask : test_lanes

	task automatic test_pattern;
		pcslst_pat_t exp_tab[4];
		exp_tab = '{PCSLST_PAT_HIGH, PCSLST_PAT_LOW, PCSLST_PAT_MIXED, PCSLST_PAT_NORMAL};
		for (int s = 0; s < 4; s++) begin
			wr(A_TEST, 32'hfff8 | 32'(4 + s), OK);
			settle();
			chk_pat(pattern_mode, exp_tab[s]);
			@(posedge aclk);
			rd(A_TEST, 32'(4 + s), OK);
		end
		jitter_req <= '{enable: 1'b1, select: 3'h2};
		wr(A_TEST, 32'h4, OK);
		settle();
		chk_pat(pattern_mode, PCSLST_PAT_HIGH);
		@(posedge aclk);
		wr(A_TEST, 32'h1, OK);
		settle();
		chk_pat(pattern_mode, PCSLST_PAT_JITTER);
		@(posedge aclk);
		jitter_req <= '0;
		settle();
		chk_pat(pattern_mode, PCSLST_PAT_NORMAL);
		@(posedge aclk);
	endtask : test_pattern

	task automatic test_reset;
		wr(A_TEST, 32'h4, OK);
		pcs_status.tx_fault <= 1'b1;
		@(posedge aclk);
		pcs_status.tx_fault <= 1'b0;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		settle();
		chk_pat(pattern_mode, PCSLST_PAT_NORMAL);
		chk_word({31'h0, irq}, 32'h0);
		@(posedge aclk);
		rd(A_TEST, 32'h0, OK);
		rd(A_ST2, 32'h8013, OK);
	endtask : test_reset

	// ============================================================
	// Main sequence and watchdog
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		test_fixed_words();
		test_faults();
		test_irq();
		test_lanes();
		test_pattern();
		test_reset();
		stop_test();
	end

	initial begin
		repeat (5000) @(posedge aclk);
		miscompares++;
		stop_test();
	end
endmodule : pcs_lane_status_test_regs_bench
`default_nettype wire
